// >>> hdl/rmc_regs.svh
// Purpose: register offsets, fields, resets and counts of the mode block
// Assumes: AHB-Lite, 32-bit words, byte addresses
// Notes: definitions only
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define RMC_OFS_MODE 4'h0
`define RMC_OFS_IRQ_STATUS 4'h4
`define RMC_OFS_IRQ_MASK 4'h8
`define RMC_OFS_STATE 4'hc
`define RMC_ADDR_W 4

// ----------------------------------------------------------------------
// mode_control fields
// ----------------------------------------------------------------------
`define RMC_BIT_SYNC_DETECT 6
`define RMC_BIT_TX_WAIT_FIELD 5
`define RMC_BIT_RX_WAIT_FIELD 4
`define RMC_BIT_SIG_IN_POLARITY 3
`define RMC_BIT_MODE_DET_DISABLE 2
`define RMC_SEED_HI 1
`define RMC_SEED_LO 0
`define RMC_MODE_RESET 8'h00
`define RMC_MODE_RW_MASK 8'h7f

// ----------------------------------------------------------------------
// interrupt fields
// ----------------------------------------------------------------------
`define RMC_IRQ_SECURE_IN 0
`define RMC_IRQ_SYNC_SEEN 1
`define RMC_IRQ_GUARD_DONE 2
`define RMC_IRQ_W 3
`define RMC_IRQ_RESET 3'h0

// ----------------------------------------------------------------------
// crc seeds and sync byte
// ----------------------------------------------------------------------
`define RMC_SEED_CODE0 16'h0000
`define RMC_SEED_CODE1 16'h6363
`define RMC_SEED_CODE2 16'ha671
`define RMC_SYNC_BYTE 8'hf0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RMC_GUARD_CYCLES 16
`define RMC_GUARD_W 8

`endif

// >>> hdl/rmc_pkg.sv
// Purpose: types of the mode block
// Assumes: nothing
// Notes: one-hot receive guard states
package rmc_pkg;

  typedef enum logic [4:0] {
    RMC_IDLE = 5'b00001,
    RMC_ARMED = 5'b00010,
    RMC_COUNT = 5'b00100,
    RMC_SYNC = 5'b01000,
    RMC_RX_ON = 5'b10000
  } rmc_guard_t;

  typedef logic [1:0] rmc_htrans_t;

endpackage

// >>> hdl/rmc_ahb_slave.sv
// Purpose: AHB-Lite address/data phase tracking for the mode block
// Assumes: single word transfers, one slave
// Notes: zero wait state, response always OKAY
`timescale 1ns/1ns
`default_nettype none
`include "rmc_regs.svh"

module rmc_ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire rmc_pkg::rmc_htrans_t htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] haddr,
  output logic rd_take,
  output logic [`RMC_ADDR_W-1:0] rd_addr,
  output logic wr_en,
  output logic [`RMC_ADDR_W-1:0] wr_addr
);
  import rmc_pkg::*;

  logic dp_write;
  logic [`RMC_ADDR_W-1:0] dp_addr;
  logic next_dp_write;
  logic [`RMC_ADDR_W-1:0] next_dp_addr;
  logic take;

  // ----------------------------------------------------------------------
  // address phase
  // ----------------------------------------------------------------------
  always_comb begin
    take = hsel & htrans[1] & hready;
    next_dp_write = take & hwrite;
    next_dp_addr = take ? haddr[`RMC_ADDR_W-1:0] : dp_addr;
    rd_take = take & ~hwrite;
    rd_addr = haddr[`RMC_ADDR_W-1:0];
    // write lands at the end of its data phase
    wr_en = dp_write;
    wr_addr = dp_addr;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= '0;
    end else begin
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/rmc_top.sv
// Purpose: mode configuration register of a contactless frontend
// Assumes: one 20 MHz clock, inputs synchronous to hclk
// Notes: read data is taken from next values, so write-then-read is fresh
//
// Function
// - bit 5 lets the transmitter start as reader or initiator only with own field on.
// - bit 4 holds the receive guard counter until an external field is seen in target mode.
// - bit 3 sets the secure-link input polarity, one active high, zero active low.
// - the internal envelope is active low whatever the pin polarity.
// - a write that changes the polarity bit raises the secure input activity event.
// - bit 2 switches the mode detector off.
// - the mode detector runs only while the anticollision command executes.
// - the seed field picks the crc start for the calc command: 0000, 6363 or a671.
// - during rf traffic the seed comes from the framing settings instead.
// - bit 6 waits for an f0 byte before receiving and prepends f0 to sends.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_regs.svh"

module rmc_top #(
  parameter int GUARD_CYCLES = `RMC_GUARD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire rmc_pkg::rmc_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic op_initiator,
  input wire logic op_target,
  input wire logic rf_field_own,
  input wire logic rf_field_ext,
  input wire logic tx_start_req,
  input wire logic rx_guard_start,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic secure_link_in,
  input wire logic auto_anticollision_cmd,
  input wire logic rf_comm_active,
  input wire logic rx_direction,
  input wire logic [1:0] rx_framing_config,
  input wire logic [1:0] tx_framing_config,
  output logic tx_start,
  output logic tx_prepend_sync,
  output logic rx_guard_busy,
  output logic rx_enable,
  output logic envelope_n,
  output logic mode_detector_run,
  output logic [15:0] crc_seed
);
  import rmc_pkg::*;

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  logic rd_take;
  logic [`RMC_ADDR_W-1:0] rd_addr;
  logic wr_en;
  logic [`RMC_ADDR_W-1:0] wr_addr;

  rmc_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .haddr(haddr),
    .rd_take(rd_take),
    .rd_addr(rd_addr),
    .wr_en(wr_en),
    .wr_addr(wr_addr)
  );

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] mode_control;
  logic [`RMC_IRQ_W-1:0] irq_status;
  logic [`RMC_IRQ_W-1:0] irq_mask;
  logic [7:0] next_mode_control;
  logic [`RMC_IRQ_W-1:0] next_irq_status;
  logic [`RMC_IRQ_W-1:0] next_irq_mask;
  logic [31:0] next_hrdata;
  logic next_irq;
  logic [`RMC_IRQ_W-1:0] events;
  logic wr_mode;
  logic wr_status;
  logic wr_mask;
  logic [7:0] wr_mode_val;

  logic sync_detect;
  logic tx_wait_field;
  logic rx_wait_field;
  logic sig_in_polarity;
  logic mode_detector_disable;
  logic [1:0] crc_seed_select;

  always_comb begin
    sync_detect = mode_control[`RMC_BIT_SYNC_DETECT];
    tx_wait_field = mode_control[`RMC_BIT_TX_WAIT_FIELD];
    rx_wait_field = mode_control[`RMC_BIT_RX_WAIT_FIELD];
    sig_in_polarity = mode_control[`RMC_BIT_SIG_IN_POLARITY];
    mode_detector_disable = mode_control[`RMC_BIT_MODE_DET_DISABLE];
    crc_seed_select = mode_control[`RMC_SEED_HI:`RMC_SEED_LO];
  end

  // ----------------------------------------------------------------------
  // secure-link input and envelope
  // ----------------------------------------------------------------------
  logic sig_active;
  logic sig_active_d;
  logic next_sig_active_d;
  logic next_envelope_n;
  logic pol_change;

  always_comb begin
    sig_active = sig_in_polarity ? secure_link_in : ~secure_link_in;
    next_envelope_n = ~sig_active;
    next_sig_active_d = sig_active;
  end

  // ----------------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------------
  always_comb begin
    wr_mode = wr_en & (wr_addr == `RMC_OFS_MODE);
    wr_status = wr_en & (wr_addr == `RMC_OFS_IRQ_STATUS);
    wr_mask = wr_en & (wr_addr == `RMC_OFS_IRQ_MASK);
    wr_mode_val = hwdata[7:0] & `RMC_MODE_RW_MASK;
    // bit 7 is not kept here, it reads as zero
    next_mode_control = wr_mode ? wr_mode_val : mode_control;
    pol_change = wr_mode &
      (wr_mode_val[`RMC_BIT_SIG_IN_POLARITY] != sig_in_polarity);
    next_irq_mask = wr_mask ? hwdata[`RMC_IRQ_W-1:0] : irq_mask;
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  logic guard_done;
  logic sync_seen;

  always_comb begin
    events = '0;
    // input activity also counts, not only the polarity write
    events[`RMC_IRQ_SECURE_IN] = pol_change | (sig_active & ~sig_active_d);
    events[`RMC_IRQ_SYNC_SEEN] = sync_seen;
    events[`RMC_IRQ_GUARD_DONE] = guard_done;
    // a set in the clearing cycle wins
    next_irq_status = (irq_status &
      ~(wr_status ? hwdata[`RMC_IRQ_W-1:0] : '0)) | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ----------------------------------------------------------------------
  // transmitter start and sync
  // ----------------------------------------------------------------------
  logic next_tx_start;
  logic next_tx_prepend_sync;

  always_comb begin
    next_tx_start = tx_start_req &
      (~(tx_wait_field & op_initiator) | rf_field_own);
    next_tx_prepend_sync = sync_detect;
  end

  // ----------------------------------------------------------------------
  // receive guard delay and sync wait
  // ----------------------------------------------------------------------
  rmc_guard_t guard_state;
  rmc_guard_t next_guard_state;
  logic [`RMC_GUARD_W-1:0] guard_cnt;
  logic [`RMC_GUARD_W-1:0] next_guard_cnt;
  logic field_ok;
  logic next_rx_guard_busy;
  logic next_rx_enable;

  always_comb begin
    field_ok = ~(rx_wait_field & op_target) | rf_field_ext;
    next_guard_state = guard_state;
    next_guard_cnt = guard_cnt;
    guard_done = 1'b0;
    sync_seen = 1'b0;
    case (guard_state)
      RMC_IDLE: begin
        if (rx_guard_start) begin
          next_guard_state = RMC_ARMED;
        end
      end
      RMC_ARMED: begin
        if (field_ok) begin
          next_guard_state = RMC_COUNT;
          next_guard_cnt = GUARD_CYCLES[`RMC_GUARD_W-1:0] - 8'h01;
        end
      end
      RMC_COUNT: begin
        if (guard_cnt == '0) begin
          guard_done = 1'b1;
          next_guard_state = sync_detect ? RMC_SYNC : RMC_RX_ON;
        end else begin
          next_guard_cnt = guard_cnt - 8'h01;
        end
      end
      RMC_SYNC: begin
        // receiver stays off until the sync byte has gone by
        if (rx_byte_valid && rx_byte == `RMC_SYNC_BYTE) begin
          sync_seen = 1'b1;
          next_guard_state = RMC_RX_ON;
        end
      end
      RMC_RX_ON: begin
        if (rx_guard_start) begin
          next_guard_state = RMC_ARMED;
        end
      end
      default: begin
        next_guard_state = RMC_IDLE;
      end
    endcase
    next_rx_guard_busy = (next_guard_state == RMC_ARMED) |
      (next_guard_state == RMC_COUNT);
    next_rx_enable = (next_guard_state == RMC_RX_ON);
  end

  // ----------------------------------------------------------------------
  // mode detector and crc seed
  // ----------------------------------------------------------------------
  logic next_mode_detector_run;
  logic [15:0] next_crc_seed;
  logic [1:0] seed_code;

  always_comb begin
    next_mode_detector_run = auto_anticollision_cmd &
      ~mode_detector_disable;
    // framing code indexes the same seed table as the register field
    seed_code = rf_comm_active ?
      (rx_direction ? rx_framing_config : tx_framing_config) :
      crc_seed_select;
    case (seed_code)
      2'h0: next_crc_seed = `RMC_SEED_CODE0;
      2'h1: next_crc_seed = `RMC_SEED_CODE1;
      2'h2: next_crc_seed = `RMC_SEED_CODE2;
      default: next_crc_seed = `RMC_SEED_CODE0;
    endcase
  end

  // ----------------------------------------------------------------------
  // read mux, from next values so a fresh write reads back
  // ----------------------------------------------------------------------
  always_comb begin
    next_hrdata = hrdata;
    if (rd_take) begin
      case (rd_addr)
        `RMC_OFS_MODE: next_hrdata = {24'h000000, next_mode_control};
        `RMC_OFS_IRQ_STATUS: next_hrdata = {29'h0, next_irq_status};
        `RMC_OFS_IRQ_MASK: next_hrdata = {29'h0, next_irq_mask};
        `RMC_OFS_STATE: next_hrdata = {next_crc_seed, 8'h00,
          guard_state[4:0], envelope_n, mode_detector_run, tx_start};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_control <= `RMC_MODE_RESET;
      irq_status <= `RMC_IRQ_RESET;
      irq_mask <= `RMC_IRQ_RESET;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      irq <= 1'b0;
      sig_active_d <= 1'b0;
      envelope_n <= 1'b1;
      tx_start <= 1'b0;
      tx_prepend_sync <= 1'b0;
      guard_state <= RMC_IDLE;
      guard_cnt <= '0;
      rx_guard_busy <= 1'b0;
      rx_enable <= 1'b0;
      mode_detector_run <= 1'b0;
      crc_seed <= `RMC_SEED_CODE0;
    end else begin
      mode_control <= next_mode_control;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      hrdata <= next_hrdata;
      // never stalls, errors never signalled
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= next_irq;
      sig_active_d <= next_sig_active_d;
      envelope_n <= next_envelope_n;
      tx_start <= next_tx_start;
      tx_prepend_sync <= next_tx_prepend_sync;
      guard_state <= next_guard_state;
      guard_cnt <= next_guard_cnt;
      rx_guard_busy <= next_rx_guard_busy;
      rx_enable <= next_rx_enable;
      mode_detector_run <= next_mode_detector_run;
      crc_seed <= next_crc_seed;
    end
  end

endmodule

`default_nettype wire

// >>> tb/rmc_props.sv
// Purpose: port assertions of the mode block
// Assumes: zero wait state slave, writes to offset 0 shadowed here
// Notes: shadow mirrors the design register, bit 7 reads 0
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// checker
// ----------------------------------------------------------------------
module rmc_props #(
  parameter int GUARD_CYCLES = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire rmc_pkg::rmc_htrans_t htrans,
  input wire logic hwrite,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic op_initiator,
  input wire logic rf_field_own,
  input wire logic tx_start_req,
  input wire logic secure_link_in,
  input wire logic auto_anticollision_cmd,
  input wire logic rf_comm_active,
  input wire logic rx_direction,
  input wire logic [1:0] rx_framing_config,
  input wire logic [1:0] tx_framing_config,
  input wire logic tx_start,
  input wire logic tx_prepend_sync,
  input wire logic rx_guard_busy,
  input wire logic rx_enable,
  input wire logic envelope_n,
  input wire logic mode_detector_run,
  input wire logic [15:0] crc_seed
);
  import rmc_pkg::*;
  logic [7:0] mode;
  logic [7:0] next_mode;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] run;
  logic [7:0] next_run;
  logic busy_d;
  function automatic logic [15:0] seed_of(input logic [1:0] c);
    return (c == 2'd1) ? 16'h6363 : ((c == 2'd2) ? 16'ha671 : 16'h0000);
  endfunction
  always_comb begin
    next_wr_pend = hsel && htrans[1] && hready && hwrite && haddr[3:0] == 4'h0;
    next_mode = wr_pend ? (hwdata[7:0] & 8'h7f) : mode;
    // run length of busy, held after busy drops so rx open can see it
    next_run = !rx_guard_busy ? run : (busy_d ? run + 8'h01 : 8'h01);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= 8'h00;
      wr_pend <= 1'b0;
      run <= 8'h00;
      busy_d <= 1'b0;
    end else begin
      mode <= next_mode;
      wr_pend <= next_wr_pend;
      run <= next_run;
      busy_d <= rx_guard_busy;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rx_open;
    $rose(rx_enable);
  endsequence
  sequence s_guard_ran;
    run >= GUARD_CYCLES;
  endsequence
  a_tx_gate: assert property (1'b1 |=> tx_start ==
    $past(tx_start_req && !(op_initiator && mode[5] && !rf_field_own)))
    else $error("tx start not gated by own field");
  a_guard_wait: assert property (s_rx_open |-> s_guard_ran)
    else $error("receiver opened before guard count ran");
  a_env_pol: assert property (1'b1 |=> envelope_n ==
    $past(secure_link_in ^ mode[3]))
    else $error("envelope level wrong for polarity");
  a_det_run: assert property (1'b1 |=> mode_detector_run ==
    $past(auto_anticollision_cmd && !mode[2]))
    else $error("mode detector run wrong");
  a_seed_calc: assert property (
    !rf_comm_active && mode[1:0] != 2'b11
    |=> crc_seed == seed_of($past(mode[1:0])))
    else $error("calc seed wrong");
  a_seed_rf: assert property (rf_comm_active |=>
    crc_seed == seed_of(
    $past(rx_direction ? rx_framing_config : tx_framing_config)))
    else $error("rf seed wrong");
  a_sync_copy: assert property (1'b1 |=>
    tx_prepend_sync == $past(mode[6]))
    else $error("sync prepend not following bit 6");
  a_ready_high: assert property (1'b1 |=> hreadyout)
    else $error("slave not ready");
  a_resp_okay: assert property (!hresp)
    else $error("response not okay");
endmodule

bind rmc_top rmc_props #(.GUARD_CYCLES(GUARD_CYCLES)) i_props (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .haddr, .hwdata, .hready,
  .hreadyout, .hresp, .op_initiator, .rf_field_own, .tx_start_req,
  .secure_link_in, .auto_anticollision_cmd, .rf_comm_active, .rx_direction,
  .rx_framing_config, .tx_framing_config, .tx_start, .tx_prepend_sync,
  .rx_guard_busy, .rx_enable, .envelope_n, .mode_detector_run, .crc_seed
);
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench of the mode block
// Assumes: zero wait state slave, short guard count
// Notes: stimulus from an lfsr seeded with f3da
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// bench
// ----------------------------------------------------------------------
module testbench;
  import rmc_pkg::*;
  localparam int GC = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  rmc_htrans_t htrans;
  logic [31:0] haddr, hwdata, hrdata, q, v;
  logic op_initiator, op_target, rf_field_own, rf_field_ext, tx_start_req;
  logic rx_guard_start, rx_byte_valid, secure_link_in, auto_anticollision_cmd;
  logic rf_comm_active, rx_direction, tx_start, tx_prepend_sync;
  logic rx_guard_busy, rx_enable, envelope_n, mode_detector_run;
  logic [7:0] rx_byte;
  logic [1:0] rx_framing_config, tx_framing_config;
  logic [15:0] crc_seed;
  int failures, total_checks, n;
  assign hready = hreadyout;
  rmc_top #(.GUARD_CYCLES(GC)) i_dut (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hsize(3'h2), .haddr, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .irq, .op_initiator, .op_target,
    .rf_field_own, .rf_field_ext, .tx_start_req, .rx_guard_start,
    .rx_byte_valid, .rx_byte, .secure_link_in, .auto_anticollision_cmd,
    .rf_comm_active, .rx_direction, .rx_framing_config, .tx_framing_config,
    .tx_start, .tx_prepend_sync, .rx_guard_busy, .rx_enable, .envelope_n,
    .mode_detector_run, .crc_seed
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] seed_of(input logic [1:0] c);
    return (c == 2'd1) ? 16'h6363 : ((c == 2'd2) ? 16'ha671 : 16'h0000);
  endfunction
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for hready, a hang ends the run
  task automatic hold;
    for (n = 0; n < 40; n++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (n == 40) begin
      chk("hready", 1'b1, hready);
      close_out();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hold();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    hold();
    q = hrdata;
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic see(input int k);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic pulse_start;
    @(posedge hclk);
    rx_guard_start <= 1'b1;
    @(posedge hclk);
    rx_guard_start <= 1'b0;
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    {hsel, hwrite, op_initiator, op_target, rf_field_own, rf_field_ext,
      tx_start_req, rx_guard_start, rx_byte_valid,
      auto_anticollision_cmd, rf_comm_active, rx_direction} = '0;
    // pin idles inactive for the reset polarity, so no activity event
    secure_link_in = 1'b1;
    {htrans, haddr, hwdata, rx_byte, rx_framing_config, tx_framing_config} = '0;
    hresetn = 1'b0;
    failures = 0;
    total_checks = 0;
    v = 32'hf3da;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc("mode reset", 32'h0, 32'h0);
    rdc("status reset", 32'h4, 32'h0);
    rdc("mask reset", 32'h8, 32'h0);
    bus(1'b1, 32'hc, 32'hffffffff);
    rdc("state read only", 32'hc, 32'hc);
    for (int i = 0; i < 8; i++) begin
      v = lfsr(v);
      bus(1'b1, 32'h0, v & 32'hbf);
      rdc("mode rw", 32'h0, v & 32'h3f);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'h0, i);
      see(1);
      chk("seed calc", seed_of(i[1:0]), crc_seed);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      rf_comm_active <= 1'b1;
      rx_direction <= i[2];
      rx_framing_config <= i[1:0];
      tx_framing_config <= ~i[1:0];
      see(1);
      chk("seed rf", seed_of(i[2] ? i[1:0] : ~i[1:0]), crc_seed);
    end
    @(posedge hclk);
    rf_comm_active <= 1'b0;
    bus(1'b1, 32'h4, 32'h7);
    bus(1'b1, 32'h8, 32'h1);
    bus(1'b1, 32'h0, 32'h8);
    see(2);
    chk("irq on change", 1'b1, irq);
    rdc("status set", 32'h4, 32'h1);
    bus(1'b1, 32'h4, 32'h1);
    bus(1'b1, 32'h0, 32'h8);
    see(2);
    chk("irq same value", 1'b0, irq);
    bus(1'b1, 32'h8, 32'h0);
    bus(1'b1, 32'h0, 32'h0);
    see(2);
    chk("irq masked", 1'b0, irq);
    rdc("status masked", 32'h4, 32'h1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 32'h0, {28'h0, i[1], 3'h0});
      secure_link_in <= i[0];
      see(1);
      chk("envelope", i[0] ^ i[1], envelope_n);
    end
    for (int i = 0; i < 16; i++) begin
      v = lfsr(v);
      bus(1'b1, 32'h0, {26'h0, i[2], 2'h0, i[3], 2'h0});
      op_initiator <= i[1];
      rf_field_own <= i[0];
      auto_anticollision_cmd <= i[0];
      tx_start_req <= v[0];
      see(1);
      chk("tx start", v[0] & !(i[2] & i[1] & !i[0]), tx_start);
      chk("mode det", i[0] & !i[3], mode_detector_run);
    end
    bus(1'b1, 32'h4, 32'h7);
    bus(1'b1, 32'h0, 32'h10);
    op_target <= 1'b1;
    pulse_start();
    see(10);
    chk("guard held", 1'b1, rx_guard_busy);
    chk("rx held", 1'b0, rx_enable);
    @(posedge hclk);
    rf_field_ext <= 1'b1;
    for (n = 0; n < GC + 6; n++) begin
      @(negedge hclk);
      if (rx_enable === 1'b1) break;
    end
    chk("rx open", 1'b1, rx_enable);
    chk("guard span", 1'b1, n >= GC);
    bus(1'b0, 32'h4, 32'h0);
    chk("guard done", 32'h4, q & 32'h4);
    bus(1'b1, 32'h0, 32'h50);
    see(1);
    chk("prepend", 1'b1, tx_prepend_sync);
    pulse_start();
    see(GC + 6);
    chk("sync wait", 1'b0, rx_enable);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      rx_byte <= i ? 8'hf0 : 8'h0f;
      rx_byte_valid <= 1'b1;
      @(posedge hclk);
      rx_byte_valid <= 1'b0;
      see(2);
      chk("sync byte", i, rx_enable);
    end
    bus(1'b0, 32'h4, 32'h0);
    chk("sync seen", 32'h2, q & 32'h2);
    close_out();
  end
endmodule
`default_nettype wire
